// File: rtl/dsag_pkg.sv
// constants, field layouts and request/answer carriers of the address generator
// assumes one core clock; the cpu decode supplies pointer values and mode
package dsag_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_XSTART = 8'h04;
    localparam logic [7:0] ADDR_XEND = 8'h08;
    localparam logic [7:0] ADDR_YSTART = 8'h0c;
    localparam logic [7:0] ADDR_YEND = 8'h10;
    localparam logic [7:0] ADDR_BREV = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    // field positions
    localparam int CTRL_XSEL_LSB = 0;
    localparam int CTRL_YSEL_LSB = 4;
    localparam int CTRL_BSEL_LSB = 8;
    localparam int CTRL_YEN_BIT = 14;
    localparam int CTRL_XEN_BIT = 15;
    localparam int BREV_EN_BIT = 15;
    localparam int STAT_WRAP_LSB = 0;
    localparam int STAT_ILL_LSB = 4;
    // reset values
    localparam logic [15:0] CTRL_RESET = 16'h0fff;
    localparam logic [15:0] BREV_RESET = 16'h0000;
    localparam logic [15:0] BOUND_RESET = 16'h0000;
    // selector value that means off, mac pointer numbers and steps
    localparam logic [3:0] SEL_OFF = 4'hf;
    localparam logic [3:0] MAC_X_LO = 4'h8;
    localparam logic [3:0] MAC_X_IDX = 4'h9;
    localparam logic [3:0] MAC_Y_LO = 4'ha;
    localparam logic [3:0] MAC_Y_IDX = 4'hb;
    localparam logic [2:0] MAC_STEP_2 = 3'h2;
    localparam logic [2:0] MAC_STEP_4 = 3'h4;
    localparam logic [2:0] MAC_STEP_6 = 3'h6;
    // generator index
    localparam int GEN_XR = 0;
    localparam int GEN_XW = 1;
    localparam int GEN_Y = 2;

    typedef enum logic [2:0] {
        MODE_IND,
        MODE_POSTINC,
        MODE_POSTDEC,
        MODE_PREINC,
        MODE_PREDEC,
        MODE_INDEXED
    } dsag_mode_t;

    typedef struct packed {
        logic valid;
        logic mac;
        logic byte_acc;
        logic [3:0] wreg;
        dsag_mode_t mode;
        logic [2:0] step;
        logic [15:0] ptr;
        logic [15:0] offset;
    } dsag_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] ea;
        logic wb_valid;
        logic [3:0] wb_reg;
        logic [15:0] wb_value;
        logic illegal;
        logic wrapped;
    } dsag_rsp_t;
endpackage

// File: rtl/dsag_modulo.sv
// circular boundary correction for one address generator
// assumes start and end are byte addresses with end the last byte of the buffer
`timescale 1ns/1ps
`default_nettype none
module dsag_modulo (
    // address in
    input wire logic [15:0] addr_in,
    input wire logic enable,
    input wire logic word_only,
    // buffer bounds
    input wire logic [15:0] start_addr,
    input wire logic [15:0] end_addr,
    // result
    output logic [15:0] addr_out,
    output logic wrapped
);
    logic [16:0] buf_len;
    logic [16:0] fixed;

    // 17 bits so a 64 kbyte buffer length does not fold to zero
    assign buf_len = {1'b0, end_addr} - {1'b0, start_addr} + 17'h0_0001;

    always_comb begin
        fixed = {1'b0, addr_in};
        wrapped = 1'b0;
        // both sides checked, an overshoot of less than one buffer length past a bound lands inside
        if (enable && (addr_in > end_addr)) begin
            fixed = {1'b0, addr_in} - buf_len;
            wrapped = 1'b1;
        end else if (enable && (addr_in < start_addr)) begin
            fixed = {1'b0, addr_in} + buf_len;
            wrapped = 1'b1;
        end
        addr_out = fixed[15:0];
        if (word_only) begin
            addr_out[0] = 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: rtl/dsag_top.sv
// address generator: x read, x write and y generators with circular and bit-reversed addressing
// assumes ahb-lite single-word transfers and one request per generator per cycle from decode
//
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dsag_top (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // generator requests from decode
    input wire dsag_pkg::dsag_req_t xr_req,
    input wire dsag_pkg::dsag_req_t xw_req,
    input wire dsag_pkg::dsag_req_t y_req,
    // generator answers to the register file and memories
    output var dsag_pkg::dsag_rsp_t xr_rsp,
    output var dsag_pkg::dsag_rsp_t xw_rsp,
    output var dsag_pkg::dsag_rsp_t y_rsp
);
    logic [15:0] ctrl_ff, xstart_ff, xend_ff, ystart_ff, yend_ff, brev_ff;
    logic [7:0] status_ff;
    logic [7:0] wr_addr_ff;
    logic wr_pend_ff;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    dsag_pkg::dsag_rsp_t rsp_ff [3];
    dsag_pkg::dsag_rsp_t nxt_rsp [3];
    dsag_pkg::dsag_req_t req [3];
    logic [15:0] linear [3];
    logic mod_active [3];
    logic brev_active;
    logic [3:0] xsel, ysel, bsel;
    logic xen, yen, brev_en;
    logic addr_phase;

    function automatic logic [15:0] rev16(input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15 - i];
        end
        return r;
    endfunction

    function automatic logic [15:0] reg_read(input logic [7:0] a, input logic [15:0] c, input logic [15:0] xs,
                                             input logic [15:0] xe, input logic [15:0] ys, input logic [15:0] ye,
                                             input logic [15:0] b, input logic [7:0] st);
        case (a)
            dsag_pkg::ADDR_CTRL: reg_read = c;
            dsag_pkg::ADDR_XSTART: reg_read = xs;
            dsag_pkg::ADDR_XEND: reg_read = xe;
            dsag_pkg::ADDR_YSTART: reg_read = ys;
            dsag_pkg::ADDR_YEND: reg_read = ye;
            dsag_pkg::ADDR_BREV: reg_read = b;
            dsag_pkg::ADDR_STATUS: reg_read = {8'h00, st};
            default: reg_read = 16'h0000;
        endcase
    endfunction

    assign req[dsag_pkg::GEN_XR] = xr_req;
    assign req[dsag_pkg::GEN_XW] = xw_req;
    assign req[dsag_pkg::GEN_Y] = y_req;

    assign xsel = ctrl_ff[dsag_pkg::CTRL_XSEL_LSB +: 4];
    assign ysel = ctrl_ff[dsag_pkg::CTRL_YSEL_LSB +: 4];
    assign bsel = ctrl_ff[dsag_pkg::CTRL_BSEL_LSB +: 4];
    assign xen = ctrl_ff[dsag_pkg::CTRL_XEN_BIT];
    assign yen = ctrl_ff[dsag_pkg::CTRL_YEN_BIT];
    assign brev_en = brev_ff[dsag_pkg::BREV_EN_BIT];

    // ahb-lite slave: zero wait states, always okay
    assign addr_phase = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= addr_phase && hwrite;
            wr_addr_ff <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= dsag_pkg::CTRL_RESET;
            brev_ff <= dsag_pkg::BREV_RESET;
            xstart_ff <= dsag_pkg::BOUND_RESET;
            xend_ff <= dsag_pkg::BOUND_RESET;
            ystart_ff <= dsag_pkg::BOUND_RESET;
            yend_ff <= dsag_pkg::BOUND_RESET;
        end else if (wr_pend_ff) begin
            case (wr_addr_ff)
                dsag_pkg::ADDR_CTRL: ctrl_ff <= hwdata[15:0];
                dsag_pkg::ADDR_XSTART: xstart_ff <= hwdata[15:0];
                dsag_pkg::ADDR_XEND: xend_ff <= hwdata[15:0];
                dsag_pkg::ADDR_YSTART: ystart_ff <= hwdata[15:0];
                dsag_pkg::ADDR_YEND: yend_ff <= hwdata[15:0];
                dsag_pkg::ADDR_BREV: brev_ff <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    // read data registered in the address phase; a write still in its data phase is bypassed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            if (wr_pend_ff && (wr_addr_ff == haddr[7:0]) && (haddr[7:0] != dsag_pkg::ADDR_STATUS)) begin
                hrdata_ff <= {16'h0000, hwdata[15:0]};
            end else begin
                hrdata_ff <= {16'h0000, reg_read(haddr[7:0], ctrl_ff, xstart_ff, xend_ff, ystart_ff, yend_ff,
                                                 brev_ff, status_ff)};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_ff <= 1'b1;
        end else begin
            hreadyout_ff <= 1'b1;
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = 1'b0;

    // bit reversal only in the x write generator, word-sized increment modes only
    assign brev_active = xw_req.valid && (bsel != dsag_pkg::SEL_OFF) && (bsel == xw_req.wreg) && brev_en
                         && !xw_req.byte_acc && !xw_req.mac
                         && ((xw_req.mode == dsag_pkg::MODE_PREINC) || (xw_req.mode == dsag_pkg::MODE_POSTINC));

    for (genvar g = 0; g < 3; g++) begin : gen_unit
        logic [15:0] moved, corr_in, corr_out, new_ptr, brev_sum, step_val;
        logic pre, post, inc, illegal, wrapped, sel_hit, is_y;

        assign is_y = (g == dsag_pkg::GEN_Y);
        assign step_val = {13'h0000, req[g].step};
        assign inc = (req[g].mode == dsag_pkg::MODE_POSTINC) || (req[g].mode == dsag_pkg::MODE_PREINC);
        assign pre = (req[g].mode == dsag_pkg::MODE_PREINC) || (req[g].mode == dsag_pkg::MODE_PREDEC);
        assign post = (req[g].mode == dsag_pkg::MODE_POSTINC) || (req[g].mode == dsag_pkg::MODE_POSTDEC);
        assign moved = inc ? req[g].ptr + step_val : req[g].ptr - step_val;
        assign linear[g] = moved;
        assign corr_in = (req[g].mode == dsag_pkg::MODE_INDEXED) ? req[g].ptr + req[g].offset
                         : ((pre || post) ? moved : req[g].ptr);
        assign sel_hit = is_y ? ((ysel != dsag_pkg::SEL_OFF) && yen && (ysel == req[g].wreg))
                              : ((xsel != dsag_pkg::SEL_OFF) && xen && (xsel == req[g].wreg));
        // x write loses modulo while bit reversal is active, x read keeps it
        assign mod_active[g] = sel_hit && !((g == dsag_pkg::GEN_XW) && brev_active);

        dsag_modulo u_modulo (
            .addr_in(corr_in),
            .enable(mod_active[g]),
            .word_only(is_y),
            .start_addr(is_y ? ystart_ff : xstart_ff),
            .end_addr(is_y ? yend_ff : xend_ff),
            .addr_out(corr_out),
            .wrapped(wrapped)
        );

        // reversed-carry add of the word-scaled pivot; mode step is ignored
        assign brev_sum = rev16(rev16(req[g].ptr) + rev16({brev_ff[14:0], 1'b0})) & 16'hfffe;
        assign new_ptr = ((g == dsag_pkg::GEN_XW) && brev_active) ? brev_sum : corr_out;

        always_comb begin
            illegal = 1'b0;
            if (req[g].mac) begin
                case (g)
                    dsag_pkg::GEN_XR: illegal = (req[g].wreg[3:1] != dsag_pkg::MAC_X_LO[3:1]);
                    dsag_pkg::GEN_Y: illegal = (req[g].wreg[3:1] != dsag_pkg::MAC_Y_LO[3:1]);
                    default: illegal = 1'b1;
                endcase
                case (req[g].mode)
                    dsag_pkg::MODE_IND: ;
                    dsag_pkg::MODE_POSTINC, dsag_pkg::MODE_POSTDEC: begin
                        if ((req[g].step != dsag_pkg::MAC_STEP_2) && (req[g].step != dsag_pkg::MAC_STEP_4)
                            && (req[g].step != dsag_pkg::MAC_STEP_6)) begin
                            illegal = 1'b1;
                        end
                    end
                    dsag_pkg::MODE_INDEXED: begin
                        if (req[g].wreg != (is_y ? dsag_pkg::MAC_Y_IDX : dsag_pkg::MAC_X_IDX)) begin
                            illegal = 1'b1;
                        end
                    end
                    default: illegal = 1'b1;
                endcase
            end
        end

        always_comb begin
            nxt_rsp[g].valid = req[g].valid;
            nxt_rsp[g].illegal = req[g].valid && illegal;
            nxt_rsp[g].wrapped = req[g].valid && !illegal && wrapped;
            nxt_rsp[g].wb_reg = req[g].wreg;
            nxt_rsp[g].wb_value = new_ptr;
            // indexed access uses the corrected address but leaves the pointer alone
            nxt_rsp[g].wb_valid = req[g].valid && !illegal && (pre || post);
            nxt_rsp[g].ea = post ? req[g].ptr : new_ptr;
            if (is_y) begin
                nxt_rsp[g].ea[0] = 1'b0;
            end
        end

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                rsp_ff[g] <= '0;
            end else begin
                rsp_ff[g] <= nxt_rsp[g];
            end
        end
    end

    assign xr_rsp = rsp_ff[dsag_pkg::GEN_XR];
    assign xw_rsp = rsp_ff[dsag_pkg::GEN_XW];
    assign y_rsp = rsp_ff[dsag_pkg::GEN_Y];

    // last wrap and illegal outcome per generator, kept until that generator is used again
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_ff <= 8'h00;
        end else begin
            for (int k = 0; k < 3; k++) begin
                if (nxt_rsp[k].valid) begin
                    status_ff[dsag_pkg::STAT_WRAP_LSB + k] <= nxt_rsp[k].wrapped;
                    status_ff[dsag_pkg::STAT_ILL_LSB + k] <= nxt_rsp[k].illegal;
                end
            end
        end
    end

    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic xr_in_bounds;
    assign xr_in_bounds = (xr_rsp.wb_value >= xstart_ff) && (xr_rsp.wb_value <= xend_ff);

    sequence xr_mac_req;
        xr_req.valid && xr_req.mac;
    endsequence

    sequence brev_req;
        brev_active;
    endsequence

    mac_route_a: assert property (xr_mac_req and (xr_req.wreg[3:1] != 3'h4) |=> xr_rsp.illegal)
        else $error("mac x read through a pointer outside w8/w9 not flagged");
    mac_index_a: assert property (xr_mac_req and (xr_req.mode == dsag_pkg::MODE_INDEXED) && (xr_req.wreg == 4'h8)
                                  |=> xr_rsp.illegal && !xr_rsp.wb_valid)
        else $error("mac indexed through w8 accepted");
    mac_mode_a: assert property (xr_mac_req and (xr_req.mode == dsag_pkg::MODE_PREINC) |=> xr_rsp.illegal)
        else $error("mac pre-increment accepted");
    y_word_a: assert property (y_rsp.valid |-> !y_rsp.ea[0] ##1 (!y_rsp.valid || !y_rsp.ea[0]))
        else $error("y address with bit 0 set");
    x_off_a: assert property (xr_req.valid && !xr_req.mac && (xr_req.mode == dsag_pkg::MODE_POSTINC) && (xsel == 4'hf)
                              |=> xr_rsp.wb_value == $past(linear[0]) && xr_rsp.ea == $past(xr_req.ptr))
        else $error("x modulo applied with selector 15");
    index_wb_a: assert property (y_req.valid && (y_req.mode == dsag_pkg::MODE_INDEXED) |=> y_rsp.valid && !y_rsp.wb_valid)
        else $error("indexed access wrote the pointer back");
    brev_lsb_a: assert property (brev_req |=> xw_rsp.wb_valid && !xw_rsp.wb_value[0] && !xw_rsp.wrapped)
        else $error("bit-reversed pointer with bit 0 set or wrapped");
    brev_byte_a: assert property (xw_req.valid && xw_req.byte_acc && !mod_active[1] && (xw_req.mode == dsag_pkg::MODE_POSTINC)
                                  |=> xw_rsp.wb_value == $past(linear[1]))
        else $error("byte access bit reversed");
    wrap_bound_a: assert property (xr_req.valid && !xr_req.mac && mod_active[0] && (xr_req.mode == dsag_pkg::MODE_PREINC)
                                   && (xr_req.ptr >= xstart_ff) && (xr_req.ptr <= xend_ff) && (xr_req.step != 3'h0)
                                   && (xend_ff >= xstart_ff) && !wr_pend_ff
                                   |=> xr_in_bounds)
        else $error("x read pointer left its circular buffer");
endmodule
`default_nettype wire

// File: verif/dsag_cpu_model.sv
// cpu decode model: presents generator requests one at a time
// assumes the generators take a request at the rising edge after it is driven
`timescale 1ns/1ps
`default_nettype none
module dsag_cpu_model (
    // clock
    input wire logic hclk,
    // requests to the generators
    output var dsag_pkg::dsag_req_t xr_req,
    output var dsag_pkg::dsag_req_t xw_req,
    output var dsag_pkg::dsag_req_t y_req
);
    initial begin
        xr_req = '0;
        xw_req = '0;
        y_req = '0;
    end
    // circular pointers never w14/w15, bit-reversed buffers start aligned
    // a spare edge before each request, so no read follows a control write at once
    task automatic issue(input int g, input dsag_pkg::dsag_req_t r);
        @(posedge hclk);
        case (g)
            0: xr_req <= r;
            1: xw_req <= r;
            default: y_req <= r;
        endcase
        @(posedge hclk);
        xr_req.valid <= 1'b0;
        xw_req.valid <= 1'b0;
        y_req.valid <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: verif/dsp_address_generator_tb_top.sv
// bench for the address generator: ahb-lite register master plus cpu request model
// assumes zero-wait slave, one-cycle generator answers
`timescale 1ns/1ps
`default_nettype none
module dsp_address_generator_tb_top;
    logic hclk, hresetn, hsel, hwrite;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic hreadyout, hresp;
    dsag_pkg::dsag_req_t xr_req, xw_req, y_req;
    dsag_pkg::dsag_rsp_t xr_rsp, xw_rsp, y_rsp;
    logic [15:0] sh [0:7];
    int failures, checks_done, cycles;
    dsag_cpu_model cpu (.hclk(hclk), .xr_req(xr_req), .xw_req(xw_req), .y_req(y_req));
    dsag_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .xr_req(xr_req), .xw_req(xw_req), .y_req(y_req),
        .xr_rsp(xr_rsp), .xw_rsp(xw_rsp), .y_rsp(y_rsp));
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task automatic conclude();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard, run needs well under a thousand cycles
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            conclude();
        end
    end
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({31'h0, got}, {31'h0, exp});
    endtask
    // one single transfer, shadow kept for expectations
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [15:0] v);
        @(posedge hclk);
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {16'h0, v};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
        if (wr && a < 8'h18) sh[a[4:2]] = v;
    endtask
    function automatic logic [15:0] rev(input logic [15:0] v);
        for (int i = 0; i < 16; i++) rev[i] = v[15 - i];
    endfunction
    // mode codes follow the package order: 0 ind 1 postinc 2 postdec 3 preinc 4 predec 5 indexed
    function automatic dsag_pkg::dsag_req_t mk(input logic mac, input logic byt, input logic [3:0] w,
        input int m, input logic [2:0] s, input logic [15:0] p, input logic [15:0] o);
        mk = {1'b1, mac, byt, w, dsag_pkg::dsag_mode_t'(3'(m)), s, p, o};
    endfunction
    // returns illegal, wb_valid, wrapped, ea, written-back pointer
    function automatic logic [34:0] expect_rsp(input int g, input dsag_pkg::dsag_req_t r);
        logic [15:0] np, a, lo, hi, ea;
        logic [3:0] sel;
        logic post, pre, br, md, ill;
        post = r.mode inside {dsag_pkg::MODE_POSTINC, dsag_pkg::MODE_POSTDEC};
        pre = r.mode inside {dsag_pkg::MODE_PREINC, dsag_pkg::MODE_PREDEC};
        br = g == 1 && sh[0][11:8] != 4'hf && sh[0][11:8] == r.wreg && sh[5][15] && !r.byte_acc && !r.mac
            && r.mode inside {dsag_pkg::MODE_PREINC, dsag_pkg::MODE_POSTINC};
        case (r.mode)
            dsag_pkg::MODE_POSTINC, dsag_pkg::MODE_PREINC: np = r.ptr + 16'(r.step);
            dsag_pkg::MODE_POSTDEC, dsag_pkg::MODE_PREDEC: np = r.ptr - 16'(r.step);
            dsag_pkg::MODE_INDEXED: np = r.ptr + r.offset;
            default: np = r.ptr;
        endcase
        if (br) np = rev(rev(r.ptr) + rev({sh[5][14:0], 1'b0})) & 16'hfffe;
        sel = (g == 2) ? sh[0][7:4] : sh[0][3:0];
        md = sel != 4'hf && sel == r.wreg && sh[0][(g == 2) ? 14 : 15] && !br;
        lo = (g == 2) ? sh[3] : sh[1];
        hi = (g == 2) ? sh[4] : sh[2];
        a = np;
        if (md && np > hi) a = np - (hi - lo + 16'h1);
        else if (md && np < lo) a = np + (hi - lo + 16'h1);
        ea = post ? r.ptr : a;
        if (g == 2) ea[0] = 1'b0;
        ill = r.mac && (g == 1 || (g == 0 && !(r.wreg inside {4'h8, 4'h9}))
            || (g == 2 && !(r.wreg inside {4'ha, 4'hb})) || !(r.mode == dsag_pkg::MODE_IND
            || (r.mode inside {dsag_pkg::MODE_POSTINC, dsag_pkg::MODE_POSTDEC} && r.step inside {3'h2, 3'h4, 3'h6})
            || (r.mode == dsag_pkg::MODE_INDEXED && r.wreg inside {4'h9, 4'hb})));
        return {ill, !ill && (post || pre), !ill && a != np, ea, a};
    endfunction
    task automatic run(input int g, input dsag_pkg::dsag_req_t r);
        dsag_pkg::dsag_rsp_t q;
        logic [34:0] e;
        e = expect_rsp(g, r);
        cpu.issue(g, r);
        #1;
        q = (g == 0) ? xr_rsp : (g == 1) ? xw_rsp : y_rsp;
        cmp_bit(q.valid, 1'b1);
        cmp_bit(q.illegal, e[34]);
        cmp_bit(q.wb_valid, e[33]);
        cmp_bit(q.wrapped, e[32]);
        cmp_word({16'h0, q.ea}, {16'h0, e[31:16]});
        cmp_word({28'h0, q.wb_reg}, {28'h0, r.wreg});
        if (e[33]) cmp_word({16'h0, q.wb_value}, {16'h0, e[15:0]});
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        hsize = 3'h2;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = '0;
        hwdata = '0;
        sh = '{16'h0fff, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
        void'($urandom(32'h653c));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(0, dsag_pkg::ADDR_CTRL, 0);
        cmp_word(d, 32'h0000_0fff);
        cmp_bit(hresp, 1'b0);
        ahb(0, dsag_pkg::ADDR_BREV, 0);
        cmp_word(d, 32'h0000_0000);
        ahb(1, 8'h1c, 16'hffff);
        ahb(0, 8'h1c, 0);
        cmp_word(d, 32'h0000_0000);
        ahb(1, dsag_pkg::ADDR_XSTART, 16'h1000);
        ahb(1, dsag_pkg::ADDR_XEND, 16'h103f);
        ahb(0, dsag_pkg::ADDR_XEND, 0);
        cmp_word(d, 32'h0000_103f);
        ahb(1, dsag_pkg::ADDR_YSTART, 16'h1020);
        ahb(1, dsag_pkg::ADDR_YEND, 16'h105f);
        run(0, mk(0, 0, 8, 1, 2, 16'h103e, 0));
        ahb(1, dsag_pkg::ADDR_CTRL, 16'h8fa8);
        run(0, mk(0, 0, 8, 1, 2, 16'h103e, 0));
        run(0, mk(0, 0, 8, 1, 6, 16'h103c, 0));
        run(0, mk(0, 0, 8, 4, 2, 16'h1000, 0));
        run(0, mk(0, 0, 8, 3, 6, 16'h103c, 0));
        run(0, mk(0, 0, 8, 5, 0, 16'h1030, 16'h0020));
        run(1, mk(0, 0, 8, 3, 4, 16'h103e, 0));
        run(2, mk(0, 0, 10, 3, 2, 16'h105e, 0));
        ahb(1, dsag_pkg::ADDR_CTRL, 16'hcfa8);
        run(2, mk(0, 0, 10, 3, 2, 16'h105e, 0));
        run(2, mk(0, 0, 10, 0, 0, 16'h1041, 0));
        ahb(1, dsag_pkg::ADDR_CTRL, 16'hcfaf);
        run(0, mk(0, 0, 15, 1, 2, 16'h103e, 0));
        ahb(1, dsag_pkg::ADDR_BREV, 16'h8008);
        ahb(1, dsag_pkg::ADDR_CTRL, 16'hc2a2);
        run(1, mk(0, 0, 2, 1, 2, 16'h1040, 0));
        run(1, mk(0, 0, 2, 1, 2, 16'h1050, 0));
        cmp_word({16'h0, xw_rsp.wb_value}, 32'h0000_1048);
        run(0, mk(0, 0, 2, 1, 2, 16'h103e, 0));
        run(1, mk(0, 0, 2, 3, 2, 16'h1000, 0));
        run(1, mk(0, 1, 2, 1, 2, 16'h1000, 0));
        run(1, mk(0, 0, 2, 4, 2, 16'h1010, 0));
        run(1, mk(0, 0, 3, 1, 2, 16'h1010, 0));
        ahb(1, dsag_pkg::ADDR_CTRL, 16'h42a2);
        run(1, mk(0, 1, 2, 1, 2, 16'h1000, 0));
        ahb(1, dsag_pkg::ADDR_CTRL, 16'hc2a2);
        ahb(1, dsag_pkg::ADDR_BREV, 16'h0008);
        run(1, mk(0, 0, 2, 1, 2, 16'h1010, 0));
        for (int s = 0; s < 8; s++) run(0, mk(1, 0, 8, 1, 3'(s), 16'h1010, 0));
        run(0, mk(1, 0, 9, 5, 0, 16'h1010, 16'h0004));
        run(0, mk(1, 0, 8, 5, 0, 16'h1010, 16'h0004));
        run(2, mk(1, 0, 11, 5, 0, 16'h1030, 16'h0004));
        run(2, mk(1, 0, 10, 0, 0, 16'h1030, 0));
        run(2, mk(1, 0, 8, 0, 0, 16'h1030, 0));
        run(0, mk(1, 0, 10, 0, 0, 16'h1030, 0));
        run(0, mk(1, 0, 8, 3, 2, 16'h1030, 0));
        run(1, mk(1, 0, 8, 0, 0, 16'h1030, 0));
        ahb(0, dsag_pkg::ADDR_STATUS, 0);
        cmp_word(d, 32'h0000_0070);
        ahb(1, dsag_pkg::ADDR_BREV, 16'h8010);
        repeat (60) begin
            run($urandom % 3, mk(0, 0, 4'($urandom % 14), $urandom % 6, 3'($urandom % 4 * 2),
                16'h1020 + 16'($urandom % 32 * 2), 16'($urandom % 4 * 2)));
        end
        conclude();
    end
endmodule
`default_nettype wire
